// ==== common/wakeup_timer_pkg.sv ====
// Constants for the 32-bit wake-up timer: register map, fields, resets.
// Assumes a 32-bit APB slave whose registers are 16 bits wide.
package wakeup_timer_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int CNT_W = 32;
   localparam int IRQ_N = 5;
   localparam int INTERVAL_W = 12;
   localparam int PRE_W = 15;

   // Byte offsets
   localparam logic [11:0] OFF_COUNT_LOW = 12'h000;
   localparam logic [11:0] OFF_COUNT_HIGH = 12'h004;
   localparam logic [11:0] OFF_CONTROL = 12'h008;
   localparam logic [11:0] OFF_INTERVAL = 12'h00C;
   localparam logic [11:0] OFF_B_LOW = 12'h010;
   localparam logic [11:0] OFF_B_HIGH = 12'h014;
   localparam logic [11:0] OFF_C_LOW = 12'h018;
   localparam logic [11:0] OFF_C_HIGH = 12'h01C;
   localparam logic [11:0] OFF_D_LOW = 12'h020;
   localparam logic [11:0] OFF_D_HIGH = 12'h024;
   localparam logic [11:0] OFF_IRQ_EN = 12'h028;
   localparam logic [11:0] OFF_STATUS = 12'h02C;
   localparam logic [11:0] OFF_CLEAR = 12'h030;
   localparam logic [11:0] OFF_A_LOW = 12'h03C;
   localparam logic [11:0] OFF_A_HIGH = 12'h040;

   // Control fields
   localparam int CTL_HOLD = 11;
   localparam int CTL_CLK_HI = 10;
   localparam int CTL_CLK_LO = 9;
   localparam int CTL_WAKE = 8;
   localparam int CTL_EN = 7;
   localparam int CTL_FREE = 6;
   localparam int CTL_FREEZE = 3;
   localparam int CTL_PRE_HI = 1;
   localparam logic [15:0] CTL_MASK = 16'h0FCB;

   // Status fields
   localparam int STA_IRQ_PEND = 6;
   localparam int STA_FROZEN = 7;
   localparam int STA_SYNC_PEND = 8;

   // Flag / enable bit positions
   localparam int IRQ_A = 0;
   localparam int IRQ_B = 1;
   localparam int IRQ_C = 2;
   localparam int IRQ_D = 3;
   localparam int IRQ_ROLL = 4;

   // Clock source and prescale codes
   localparam logic [1:0] SRC_PCLK = 2'h0;
   localparam logic [1:0] SRC_XTAL = 2'h1;
   localparam logic [1:0] SRC_OSC = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;
   localparam logic [1:0] PRE_1 = 2'h0;
   localparam logic [1:0] PRE_16 = 2'h1;
   localparam logic [1:0] PRE_256 = 2'h2;
   localparam logic [14:0] TERM_1 = 15'h0000;
   localparam logic [14:0] TERM_4 = 15'h0003;
   localparam logic [14:0] TERM_16 = 15'h000F;
   localparam logic [14:0] TERM_256 = 15'h00FF;
   localparam logic [14:0] TERM_32768 = 15'h7FFF;

   // Interval sits this far up inside field A
   localparam int A_SHIFT = 5;
   // Slow-clock edges a clear or enable change takes to cross
   localparam logic [1:0] SLOW_SYNC_EDGES = 2'h2;

   // Reset values
   localparam logic [15:0] RST_CONTROL = 16'h0040;
   localparam logic [11:0] RST_INTERVAL = 12'h0C8;
   localparam logic [31:0] RST_A = 32'h0000_1900;
   localparam logic [31:0] RST_B = 32'h0000_1FFF;
   localparam logic [31:0] RST_C = 32'h0000_2FFF;
   localparam logic [31:0] RST_D = 32'h0000_3FFF;
   localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
endpackage : wakeup_timer_pkg

// ==== src/slow_edge_sync.sv ====
// Three-flop synchroniser with rising-edge pulse for a slow clock pin.
// Assumes the pin toggles well below half the pclk rate.
`timescale 1ns/1ns
`default_nettype none
module slow_edge_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic rise
);
   logic meta;
   logic s2;
   logic s3;
   logic settled;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         settled <= 1'b0;
      end else begin
         meta <= pin;
         s2 <= meta;
         s3 <= s2;
         if (s2 == s3) begin
            settled <= s3;
         end
      end
   end

   // Edge counts once the second and third stages agree on a new level
   assign rise = s2 & s3 & ~settled;
endmodule : slow_edge_sync
`default_nettype wire

// ==== src/tick_prescaler.sv ====
// Divides a source pulse stream by 1, 4, 16, 256 or 32768.
// Assumes src_pulse is a one-cycle pulse on pclk.
`timescale 1ns/1ns
`default_nettype none
module tick_prescaler
   import wakeup_timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic src_is_pclk,
   input wire logic [1:0] pre,
   input wire logic src_pulse,
   output logic tick
);
   import wakeup_timer_pkg::*;

   logic [PRE_W-1:0] cnt;
   logic [PRE_W-1:0] term;
   logic at_term;

   // Divide by 4 in place of 1 on the peripheral clock
   assign term = (pre == PRE_1) ? (src_is_pclk ? TERM_4 : TERM_1) : // [R3]
                 (pre == PRE_16) ? TERM_16 :                        // [R2]
                 (pre == PRE_256) ? TERM_256 : TERM_32768;
   assign at_term = (cnt == term);
   assign tick = run & src_pulse & at_term;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else if (!run) begin
         cnt <= '0;
      end else if (src_pulse) begin
         cnt <= at_term ? '0 : cnt + 15'h0001;
      end
   end
endmodule : tick_prescaler
`default_nettype wire

// ==== src/wakeup_timer_32bit.sv ====
// 32-bit wake-up timer with four compare fields and APB registers.
// Assumes pclk runs always; periph_clock_on marks peripheral clock gating.
// Function
// R1: Control bits 10:9 pick source; 00 peripheral clock, 01 crystal.
// R2: Selected source divided by 1, 16, 256 or 32768.
// R3: Peripheral clock with prescale code 00 divides by 4.
// R4: Counter keeps running from a slow source while peripheral clock stops.
// R5: Free-running mode counts 0 to all ones then wraps.
// R6: Periodic mode counts 0 up to field D then returns to 0.
// R7: Control bit 7 starts; clearing it stops and zeroes the counter.
// R8: With bit 3 set, low-half read freezes high half until read.
// R9: Interval write loads bits 16:5 of field A.
// R10: On field A match, add interval times 32 within the limit.
// R11: Free mode overflow: A becomes old plus 32 interval minus all ones.
// R12: Periodic overflow: A becomes old plus 32 interval minus D.
// R13: Bit 11 blocks interval load; software brackets interval writes with it.
// R14: Software disables B or C interrupt before rewriting that field.
// R15: Software rewrites D only when stopped, or free mode with D masked.
// R16: Five maskable interrupt sources, each cleared by writing its bit.
// R17: On a slow source a clear lands two slow clock cycles later.
// R18: Status bit 6 shows interrupts pending in slow domain.
// R19: Software programs compare fields before enabling.
// R20: Software turns the crystal on before selecting it.
// R21: Transfers into the slow domains are synchronised in hardware.
// R22: Free mode needs software to move B, C and D after matches.
// R23: Code 10 picks internal oscillator, code 11 the external pin.
// R24: Compare flag sets only when enabled; cleared by a written one.
// R25: Status bit 8 set on enable change, cleared once synchronised.
// R26: Enable bit 4 rollover, bits 3 to 0 fields D, C, B, A.
// R27: Counter steps by one per tick, held at zero while disabled.
// R28: Writing one half of a compare field leaves the other half.
`timescale 1ns/1ns
`default_nettype none
module wakeup_timer_32bit
   import wakeup_timer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wakeup_timer_pkg::ADDR_W-1:0] paddr,
   input wire logic [wakeup_timer_pkg::DATA_W-1:0] pwdata,
   output logic [wakeup_timer_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic periph_clock_on,
   input wire logic low_freq_crystal,
   input wire logic low_freq_oscillator,
   input wire logic external_clock_pin,
   output logic timer_irq,
   output logic wake_up
);
   import wakeup_timer_pkg::*;

   logic [CNT_W-1:0] counter_value;
   logic [CNT_W-1:0] compare_field_a;
   logic [CNT_W-1:0] compare_field_b;
   logic [CNT_W-1:0] compare_field_c;
   logic [CNT_W-1:0] compare_field_d;
   logic [REG_W-1:0] timer_control;
   logic [INTERVAL_W-1:0] field_a_interval;
   logic [IRQ_N-1:0] interrupt_enable;
   logic [IRQ_N-1:0] flags;
   logic [IRQ_N-1:0] clear_pending;
   logic [1:0] clear_edges;
   logic [1:0] sync_edges;
   logic enable_sync_pending;
   logic frozen;
   logic [REG_W-1:0] frozen_high;
   logic [DATA_W-1:0] rd_data;
   logic rd_mapped;

   // Bus decode
   wire bus_done = psel & penable & pready;
   wire bus_wr = bus_done & pwrite;
   wire bus_rd = bus_done & ~pwrite;
   wire wr_control = bus_wr & (paddr == OFF_CONTROL);
   wire wr_interval = bus_wr & (paddr == OFF_INTERVAL);
   wire wr_irq_en = bus_wr & (paddr == OFF_IRQ_EN);
   wire wr_clear = bus_wr & (paddr == OFF_CLEAR);
   wire wr_a_lo = bus_wr & (paddr == OFF_A_LOW);
   wire wr_a_hi = bus_wr & (paddr == OFF_A_HIGH);
   wire wr_b_lo = bus_wr & (paddr == OFF_B_LOW);
   wire wr_b_hi = bus_wr & (paddr == OFF_B_HIGH);
   wire wr_c_lo = bus_wr & (paddr == OFF_C_LOW);
   wire wr_c_hi = bus_wr & (paddr == OFF_C_HIGH);
   wire wr_d_lo = bus_wr & (paddr == OFF_D_LOW);
   wire wr_d_hi = bus_wr & (paddr == OFF_D_HIGH);
   // Capture with the low read data itself, so both halves agree
   wire rd_low = psel & penable & ~pready & ~pwrite
                 & (paddr == OFF_COUNT_LOW);
   wire rd_high = bus_rd & (paddr == OFF_COUNT_HIGH);
   wire [REG_W-1:0] wdata16 = pwdata[REG_W-1:0];

   // Control fields
   wire run = timer_control[CTL_EN];
   wire free_mode = timer_control[CTL_FREE];
   wire interval_load_hold = timer_control[CTL_HOLD];
   wire freeze_en = timer_control[CTL_FREEZE];
   wire [1:0] clk_sel = timer_control[CTL_CLK_HI:CTL_CLK_LO];
   wire [1:0] pre_sel = timer_control[CTL_PRE_HI:0];
   wire src_is_pclk = (clk_sel == SRC_PCLK);

   // Slow clock pins, each through three flops
   logic xtal_rise;
   logic osc_rise;
   logic ext_rise;

   slow_edge_sync xtal_sync (                                  // [R21]
      .pclk(pclk),
      .presetn(presetn),
      .pin(low_freq_crystal),
      .rise(xtal_rise)
   );
   slow_edge_sync osc_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(low_freq_oscillator),
      .rise(osc_rise)
   );
   slow_edge_sync ext_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(external_clock_pin),
      .rise(ext_rise)
   );

   // Slow sources count on regardless of peripheral clock gating
   wire src_pulse = src_is_pclk ? periph_clock_on :            // [R1] [R4]
                    (clk_sel == SRC_XTAL) ? xtal_rise :        // [R1]
                    (clk_sel == SRC_OSC) ? osc_rise : ext_rise; // [R23]

   logic tick;
   tick_prescaler prescaler (                                  // [R2]
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .src_is_pclk(src_is_pclk),
      .pre(pre_sel),
      .src_pulse(src_pulse),
      .tick(tick)
   );

   // Counter next value
   wire at_top = free_mode ? (counter_value == ALL_ONES)       // [R5]
                           : (counter_value == compare_field_d); // [R6]
   wire [CNT_W-1:0] next_count = at_top ? '0
                                        : counter_value + 32'h1; // [R27]
   wire step = run & tick;

   // Match events on the value the counter is about to take
   wire [IRQ_N-1:0] events;
   assign events[IRQ_A] = (next_count == compare_field_a);
   assign events[IRQ_B] = (next_count == compare_field_b);
   assign events[IRQ_C] = (next_count == compare_field_c);
   assign events[IRQ_D] = (next_count == compare_field_d);
   assign events[IRQ_ROLL] = free_mode & (next_count == ALL_ONES); // [R26]
   wire [IRQ_N-1:0] set_flags = events & interrupt_enable
                                & {IRQ_N{step}};               // [R16] [R24]

   // Field A advance
   wire [CNT_W:0] a_sum = {1'b0, compare_field_a}
                        + {16'h0000, field_a_interval, 5'h00}; // [R10]
   wire [CNT_W:0] a_limit = free_mode ? {1'b0, ALL_ONES}
                                      : {1'b0, compare_field_d};
   wire a_over = (a_sum > a_limit);
   wire [CNT_W:0] a_diff = a_sum - a_limit;                    // [R11] [R12]
   wire [CNT_W-1:0] next_a = a_over ? a_diff[CNT_W-1:0]
                                    : a_sum[CNT_W-1:0];
   wire a_match = step & events[IRQ_A];

   // Clear path; on a slow source it waits two source edges
   wire [IRQ_N-1:0] clear_req = wr_clear ? pwdata[IRQ_N-1:0] : '0;
   wire clear_done = (clear_pending != '0) & src_pulse
                     & (clear_edges == SLOW_SYNC_EDGES - 2'h1);
   wire [IRQ_N-1:0] clear_now = src_is_pclk ? clear_req
                              : (clear_done ? clear_pending : '0); // [R17]
   // A set in the clearing cycle survives
   wire [IRQ_N-1:0] next_flags = (flags & ~clear_now) | set_flags; // [R24]
   wire slow_domain_irq_pending = (flags != '0)
                                  | (clear_pending != '0);     // [R18]
   wire enable_change = wr_control & (wdata16[CTL_EN] != run);

   // APB answer: one wait state, data registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel & penable & ~pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? '0 : rd_data;
         pslverr <= ~rd_mapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Read mux
   always_comb begin
      rd_data = '0;
      rd_mapped = 1'b1;
      unique case (paddr)
         OFF_COUNT_LOW: rd_data[REG_W-1:0] = counter_value[15:0];
         OFF_COUNT_HIGH: rd_data[REG_W-1:0] = frozen ? frozen_high
                                              : counter_value[31:16]; // [R8]
         OFF_CONTROL: rd_data[REG_W-1:0] = timer_control;
         OFF_INTERVAL: rd_data[INTERVAL_W-1:0] = field_a_interval;
         OFF_A_LOW: rd_data[REG_W-1:0] = compare_field_a[15:0];
         OFF_A_HIGH: rd_data[REG_W-1:0] = compare_field_a[31:16];
         OFF_B_LOW: rd_data[REG_W-1:0] = compare_field_b[15:0];
         OFF_B_HIGH: rd_data[REG_W-1:0] = compare_field_b[31:16];
         OFF_C_LOW: rd_data[REG_W-1:0] = compare_field_c[15:0];
         OFF_C_HIGH: rd_data[REG_W-1:0] = compare_field_c[31:16];
         OFF_D_LOW: rd_data[REG_W-1:0] = compare_field_d[15:0];
         OFF_D_HIGH: rd_data[REG_W-1:0] = compare_field_d[31:16];
         OFF_IRQ_EN: rd_data[IRQ_N-1:0] = interrupt_enable;
         OFF_STATUS: begin
            rd_data[IRQ_N-1:0] = flags;
            rd_data[STA_IRQ_PEND] = slow_domain_irq_pending;   // [R18]
            rd_data[STA_FROZEN] = frozen;
            rd_data[STA_SYNC_PEND] = enable_sync_pending;      // [R25]
         end
         OFF_CLEAR: rd_data = '0;
         default: rd_mapped = 1'b0;
      endcase
   end

   // Control, enables, interval
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control <= RST_CONTROL;
         interrupt_enable <= '0;
         field_a_interval <= RST_INTERVAL;
      end else begin
         if (wr_control) begin
            timer_control <= wdata16 & CTL_MASK;               // [R7]
         end
         if (wr_irq_en) begin
            interrupt_enable <= pwdata[IRQ_N-1:0];             // [R26]
         end
         if (wr_interval) begin
            field_a_interval <= pwdata[INTERVAL_W-1:0];
         end
      end
   end

   // Counter: zero while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value <= '0;
      end else if (!run) begin
         counter_value <= '0;                                  // [R7] [R27]
      end else if (tick) begin
         counter_value <= next_count;                          // [R5] [R6]
      end
   end

   // Field A: hardware advance wins over a bus write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_field_a <= RST_A;
      end else if (a_match) begin
         compare_field_a <= next_a;                            // [R10]
      end else if (wr_interval & ~interval_load_hold) begin
         compare_field_a[16:A_SHIFT] <= pwdata[INTERVAL_W-1:0]; // [R9] [R13]
      end else if (wr_a_lo) begin
         compare_field_a[15:0] <= wdata16;                     // [R28]
      end else if (wr_a_hi) begin
         compare_field_a[31:16] <= wdata16;                    // [R28]
      end
   end

   // Software-owned fields, half at a time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_field_b <= RST_B;
         compare_field_c <= RST_C;
         compare_field_d <= RST_D;
      end else begin
         if (wr_b_lo) compare_field_b[15:0] <= wdata16;        // [R28]
         if (wr_b_hi) compare_field_b[31:16] <= wdata16;
         if (wr_c_lo) compare_field_c[15:0] <= wdata16;
         if (wr_c_hi) compare_field_c[31:16] <= wdata16;
         if (wr_d_lo) compare_field_d[15:0] <= wdata16;
         if (wr_d_hi) compare_field_d[31:16] <= wdata16;
      end
   end

   // Flags and delayed clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
         clear_pending <= '0;
         clear_edges <= '0;
      end else begin
         flags <= next_flags;                                  // [R16]
         if (src_is_pclk) begin
            clear_pending <= '0;
            clear_edges <= '0;
         end else if (clear_req != '0) begin // [R17]
            clear_pending <= (clear_done ? '0 : clear_pending) | clear_req;
            clear_edges <= '0;
         end else if (clear_done) begin
            clear_pending <= '0;
            clear_edges <= '0;
         end else if ((clear_pending != '0) & src_pulse) begin
            clear_edges <= clear_edges + 2'h1;
         end
      end
   end

   // Enable change crossing into the source domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_sync_pending <= 1'b0;
         sync_edges <= '0;
      end else if (enable_change) begin
         enable_sync_pending <= 1'b1;                          // [R25]
         sync_edges <= '0;
      end else if (enable_sync_pending & src_pulse) begin
         if (sync_edges == SLOW_SYNC_EDGES - 2'h1) begin
            enable_sync_pending <= 1'b0;                       // [R25] [R21]
         end
         sync_edges <= sync_edges + 2'h1;
      end
   end

   // Freeze of the high half between the two reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frozen <= 1'b0;
         frozen_high <= '0;
      end else if (rd_low & freeze_en & ~frozen) begin
         frozen <= 1'b1;                                       // [R8]
         frozen_high <= counter_value[31:16];
      end else if (rd_high | ~freeze_en) begin
         frozen <= 1'b0;                                       // [R8]
      end
   end

   // Outputs straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq <= 1'b0;
         wake_up <= 1'b0;
      end else begin
         timer_irq <= (next_flags != '0);                      // [R16]
         wake_up <= timer_control[CTL_WAKE] & (next_flags != '0);
      end
   end

   count_stop_a: assert property ( // [R7]
      @(posedge pclk) disable iff (!presetn)
      !run |=> counter_value == '0)
      else $error("counter not zero while stopped");

   count_step_a: assert property ( // [R27]
      @(posedge pclk) disable iff (!presetn)
      step && !at_top |=> counter_value == $past(counter_value) + 32'h1)
      else $error("counter did not step by one");

   periodic_wrap_a: assert property ( // [R6]
      @(posedge pclk) disable iff (!presetn)
      step && !free_mode && counter_value == compare_field_d
      |=> counter_value == '0)
      else $error("periodic counter did not return to zero");

   flag_set_a: assert property ( // [R24]
      @(posedge pclk) disable iff (!presetn)
      step && events[IRQ_D] && interrupt_enable[IRQ_D]
      |=> flags[IRQ_D] && timer_irq)
      else $error("enabled match did not raise flag and irq");

   masked_match_a: assert property ( // [R16]
      @(posedge pclk) disable iff (!presetn)
      !flags[IRQ_C] && !interrupt_enable[IRQ_C] |=> !flags[IRQ_C])
      else $error("masked match set a flag");

   fast_clear_a: assert property ( // [R16]
      @(posedge pclk) disable iff (!presetn)
      src_is_pclk && clear_req[IRQ_D] && !set_flags[IRQ_D]
      |=> !flags[IRQ_D])
      else $error("clear on peripheral clock did not act");

   slow_clear_a: assert property ( // [R17]
      @(posedge pclk) disable iff (!presetn)
      !src_is_pclk && clear_req[IRQ_D] && flags[IRQ_D]
      && !src_pulse && !set_flags[IRQ_D] |=> flags[IRQ_D])
      else $error("slow clear acted too early");

   a_advance_a: assert property ( // [R10]
      @(posedge pclk) disable iff (!presetn)
      a_match && !a_over |=> compare_field_a ==
      $past(compare_field_a) + {15'h0000, $past(field_a_interval), 5'h00})
      else $error("field A did not advance by interval");

   pending_bit_a: assert property ( // [R18]
      @(posedge pclk) disable iff (!presetn)
      flags != '0 |-> slow_domain_irq_pending)
      else $error("pending bit low with a flag set");

   freeze_hold_a: assert property ( // [R8]
      @(posedge pclk) disable iff (!presetn)
      frozen && !rd_high && freeze_en |=> $stable(frozen_high) && frozen)
      else $error("frozen high half changed");

   sync_flag_a: assert property ( // [R25]
      @(posedge pclk) disable iff (!presetn)
      enable_change |=> enable_sync_pending)
      else $error("enable change not flagged");
endmodule : wakeup_timer_32bit
`default_nettype wire

// ==== tb/wakeup_timer_32bit_tb.sv ====
// Self-checking bench for the wake-up timer over its APB port.
// Assumes only the crystal pin is driven; the other slow pins stay idle.
`timescale 1ns/1ns
`default_nettype none
module wakeup_timer_32bit_tb;
   import wakeup_timer_pkg::*;
   typedef struct {logic [31:0] e; logic [31:0] m; logic er;} note_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, timer_irq, wake_up;
   logic xtal = 0, xtal_on = 0, pclk_on = 1;
   note_t q[$];
   note_t nt;
   int err_count = 0, n_compared = 0, cyc = 0, t, seed = 32'h26c9d160;
   logic [31:0] d;
   localparam logic [11:0] RA [8] = '{OFF_CONTROL, OFF_INTERVAL, OFF_B_LOW,
      OFF_C_LOW, OFF_D_LOW, OFF_A_LOW, OFF_A_HIGH, OFF_CLEAR};
   localparam logic [15:0] RV [8] = '{16'h0040, 16'h00C8, 16'h1FFF,
      16'h2FFF, 16'h3FFF, 16'h1900, 16'h0000, 16'h0000};
   wakeup_timer_32bit wakeup_timer_32bit_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_clock_on(pclk_on), .low_freq_crystal(xtal),
      .low_freq_oscillator(1'b0), .external_clock_pin(1'b0),
      .timer_irq(timer_irq), .wake_up(wake_up));
   initial begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   // Crystal at a sixteenth of pclk, well under the pclk/4 limit
   always @(posedge pclk) if (xtal_on && cyc % 8 == 0) xtal <= ~xtal;
   task print_verdict;
      if (err_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_compared++;
      if (seen !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask : check
   // Driver notes the expected answer; monitor below compares it
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
            input logic [31:0] e, input logic [31:0] m, input logic er);
      int n;
      q.push_back('{e, m, er});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         print_verdict;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, '0, '0, 1'b0);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, '0, e, m, 1'b0);
   endtask : rd
   // Bounded wait; a hang ends the run as a failure
   task wirq(input logic l);
      int n;
      n = 0;
      while (timer_irq !== l && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 300) begin
         err_count++;
         print_verdict;
      end
   endtask : wirq
   always @(posedge pclk) begin
      if (pready === 1'b1 && q.size() > 0) begin
         nt = q.pop_front();
         check("prdata", prdata & nt.m, nt.e);
         check("pslverr", {31'h0, pslverr}, {31'h0, nt.er});
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(RA[i], {16'h0, RV[i]}, '1);
      apb(1'b0, 12'h034, '0, '0, '1, 1'b1);
      d = $random(seed);
      wr(OFF_B_LOW, {16'h0, d[15:0]});
      rd(OFF_B_LOW, {16'h0, d[15:0]}, '1);
      rd(OFF_B_HIGH, '0, '1);
      // Periodic, D of 3, pclk source with code 00: 16 pclk per period
      wr(OFF_D_LOW, 32'h3);
      wr(OFF_IRQ_EN, 32'h8);
      wr(OFF_CONTROL, 32'h0080);
      wirq(1'b1);
      wr(OFF_CLEAR, 32'h8);
      wirq(1'b0);
      wirq(1'b1);
      t = cyc;
      rd(OFF_STATUS, 32'h0048, '1);
      wr(OFF_CLEAR, 32'h8);
      wirq(1'b0);
      wirq(1'b1);
      check("period", cyc - t, 32'd16);
      wr(OFF_CONTROL, 32'h0);
      rd(OFF_COUNT_LOW, '0, '1);
      wr(OFF_CONTROL, 32'h00C8);
      rd(OFF_COUNT_LOW, '0, '0);
      rd(OFF_STATUS, 32'h0080, 32'h0080);
      rd(OFF_COUNT_HIGH, '0, '0);
      rd(OFF_STATUS, '0, 32'h0080);
      // Interval lands in A bits 16:5 only while the load is not held
      wr(OFF_CONTROL, 32'h0);
      d = $random(seed) & 32'hFFF;
      wr(OFF_INTERVAL, d);
      rd(OFF_A_LOW, {16'h0, d[10:0], 5'h00}, '1);
      rd(OFF_A_HIGH, {31'h0, d[11]}, '1);
      wr(OFF_CONTROL, 32'h0800);
      wr(OFF_INTERVAL, ~d & 32'hFFF);
      rd(OFF_A_LOW, {16'h0, d[10:0], 5'h00}, '1);
      // Crystal source: clear waits two slow edges, counting survives gating
      xtal_on <= 1'b1;
      wr(OFF_CONTROL, 32'h0300);
      wr(OFF_CLEAR, 32'h8);
      rd(OFF_STATUS, 32'h0048, 32'h004F);
      wirq(1'b0);
      wr(OFF_CONTROL, 32'h0380);
      pclk_on <= 1'b0;
      wirq(1'b1);
      check("wake_up", {31'h0, wake_up}, 32'h1);
      // Free mode: software moves D after a match, A advances by itself
      pclk_on <= 1'b1;
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_CLEAR, 32'h8);
      wr(OFF_INTERVAL, 32'h1);
      wr(OFF_CONTROL, 32'h00C0);
      wirq(1'b1);
      wr(OFF_IRQ_EN, 32'h0);
      wr(OFF_D_LOW, 32'h20);
      wr(OFF_IRQ_EN, 32'h8);
      wr(OFF_CLEAR, 32'h8);
      wirq(1'b0);
      wirq(1'b1);
      rd(OFF_COUNT_LOW, 32'h20, 32'hFFFC);
      rd(OFF_A_LOW, 32'h40, '1);
      print_verdict;
   end
endmodule : wakeup_timer_32bit_tb
`default_nettype wire
